// File: dead_band_cfg.svh
`ifndef DEAD_BAND_CFG_SVH
`define DEAD_BAND_CFG_SVH
`define OFS_CTRL0 12'h000
`define OFS_CTRL1 12'h004
`define OFS_SHDN 12'h008
`define OFS_DB_FALL 12'h00c
`define OFS_DB_RISE 12'h010
`define DB_WIDTH 6
`define CTRL0_CS_BIT 0
`define CTRL0_IMPL_MASK 8'hf9
`define CTRL1_IMPL_MASK 8'hf3
`define SHDN_IMPL_MASK 8'hc7
`define CTRL_RESET 8'h00
`define DB_ONE 6'h01
`define DB_ZERO 6'h00
`endif

// File: dead_band_pkg.sv
package dead_band_pkg;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_WAIT = 3'b010,
    ST_DONE = 3'b100
  } db_state_t;
endpackage

// File: complementary_dead_band_delay.sv
`include "dead_band_cfg.svh"
module complementary_dead_band_delay (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Waveform and alternate dead-band clock, both asynchronous
  input wire logic wave_in,
  input wire logic alt_clk,
  // Complementary outputs
  output logic out_a,
  output logic out_b
);

  ////////////////////////////////////////////////////////////////////////////
  logic [7:0] ctrl0_reg;
  logic [7:0] ctrl1_reg;
  logic [7:0] shdn_reg;
  logic [5:0] rise_reg;
  logic [5:0] fall_reg;
  logic [1:0] wave_sync_reg;
  logic [1:0] alt_sync_reg;
  logic wave_q_reg;
  logic alt_q_reg;
  logic [5:0] cnt_reg;
  logic [5:0] cnt_next;
  logic pend_reg;
  logic pend_next;
  dead_band_pkg::db_state_t state_reg;
  dead_band_pkg::db_state_t state_next;
  logic out_a_next;
  logic out_b_next;
  logic [31:0] rdata_next;

  wire acc = psel && penable && !pready;
  wire wr = acc && pwrite;
  // Full 12-bit compare, so aliases of a register read as unmapped
  function automatic logic addr_is(input logic [11:0] a,
      input logic [11:0] ofs);
    addr_is = (a == ofs);
  endfunction

  wire hit_c0 = addr_is(paddr, `OFS_CTRL0);
  wire hit_c1 = addr_is(paddr, `OFS_CTRL1);
  wire hit_sd = addr_is(paddr, `OFS_SHDN);
  wire hit_df = addr_is(paddr, `OFS_DB_FALL);
  wire hit_dr = addr_is(paddr, `OFS_DB_RISE);
  wire hit_any = hit_c0 | hit_c1 | hit_sd | hit_df | hit_dr;
  wire [7:0] wb = pwdata[7:0];

  ////////////////////////////////////////////////////////////////////////////
  // Upper count bits are not stored, so they read zero
  assign rdata_next = hit_c0 ? {24'h000000, ctrl0_reg} :
                      hit_c1 ? {24'h000000, ctrl1_reg} :
                      hit_sd ? {24'h000000, shdn_reg} :
                      hit_df ? {26'h0000000, fall_reg} :
                      hit_dr ? {26'h0000000, rise_reg} : 32'h00000000;

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      pready <= 1'b0;
    end else begin
      pready <= acc;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      pslverr <= 1'b0;
    end else begin
      pslverr <= acc && !hit_any;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      prdata <= 32'h00000000;
    end else begin
      prdata <= (acc && !pwrite) ? rdata_next : 32'h00000000;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      ctrl0_reg <= `CTRL_RESET;
    end else if (wr && hit_c0) begin
      ctrl0_reg <= wb & `CTRL0_IMPL_MASK;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      ctrl1_reg <= `CTRL_RESET;
    end else if (wr && hit_c1) begin
      ctrl1_reg <= wb & `CTRL1_IMPL_MASK;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      shdn_reg <= `CTRL_RESET;
    end else if (wr && hit_sd) begin
      shdn_reg <= wb & `SHDN_IMPL_MASK;
    end
  end

  // Not on sys_rst: counts survive ordinary resets
  always_ff @(posedge ref_clk) begin
    if (wr && hit_dr) rise_reg <= wb[`DB_WIDTH-1:0];
    if (wr && hit_df) fall_reg <= wb[`DB_WIDTH-1:0];
  end

  ////////////////////////////////////////////////////////////////////////////
  // Two-stage synchronisers; only the second stage is read
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      wave_sync_reg <= 2'b00;
      wave_q_reg <= 1'b0;
    end else begin
      wave_sync_reg <= {wave_sync_reg[0], wave_in};
      wave_q_reg <= wave_sync_reg[1];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      alt_sync_reg <= 2'b00;
      alt_q_reg <= 1'b0;
    end else begin
      alt_sync_reg <= {alt_sync_reg[0], alt_clk};
      alt_q_reg <= alt_sync_reg[1];
    end
  end

  wire wave = wave_sync_reg[1];
  wire edge_any = wave ^ wave_q_reg;
  // Alternate clock is sampled, so it must run well below ref_clk
  wire use_alt = ctrl0_reg[`CTRL0_CS_BIT];
  wire tick = use_alt ? (alt_sync_reg[1] && !alt_q_reg) : 1'b1;
  // Alt ticks come at any phase, so one extra tick keeps the minimum at n
  wire [5:0] db_end = use_alt ? `DB_ZERO : `DB_ONE;
  wire [5:0] sel_cnt = wave ? rise_reg : fall_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Rising edge: out_b drops at once, out_a rises after the dead band.
  // Falling edge: out_a drops at once, out_b rises after the dead band.
  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    pend_next = pend_reg;
    out_a_next = out_a;
    out_b_next = out_b;
    if (edge_any) begin
      out_a_next = 1'b0;
      out_b_next = 1'b0;
      pend_next = wave;
      if (sel_cnt == `DB_ZERO) begin
        out_a_next = wave;
        out_b_next = !wave;
        state_next = dead_band_pkg::ST_IDLE;
      end else begin
        cnt_next = sel_cnt;
        state_next = dead_band_pkg::ST_WAIT;
      end
    end else begin
      case (state_reg)
        dead_band_pkg::ST_IDLE: state_next = dead_band_pkg::ST_IDLE;
        dead_band_pkg::ST_WAIT: begin
          // Unsynchronised tick phase gives n..n+1 counts
          if (tick) begin
            if (cnt_reg == db_end) state_next = dead_band_pkg::ST_DONE;
            else cnt_next = cnt_reg - `DB_ONE;
          end
        end
        dead_band_pkg::ST_DONE: begin
          out_a_next = pend_reg;
          out_b_next = !pend_reg;
          state_next = dead_band_pkg::ST_IDLE;
        end
        default: state_next = dead_band_pkg::ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      state_reg <= dead_band_pkg::ST_IDLE;
      cnt_reg <= `DB_ZERO;
      pend_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      pend_reg <= pend_next;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      out_a <= 1'b0;
      out_b <= 1'b0;
    end else begin
      out_a <= out_a_next;
      out_b <= out_b_next;
    end
  end

endmodule

// File: alt_tick_src.sv
module alt_tick_src (
  // Alternate dead-band clock
  output logic alt_clk
);
  timeunit 1ns;
  timeprecision 1ns;
  // Odd half period keeps it out of step with ref_clk
  initial alt_clk = 1'b0;
  always #97 alt_clk = ~alt_clk;
endmodule

// File: dead_band_assertions.sv
module dead_band_checker (
  // Clock, reset and bus
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Waveform
  input wire logic wave_in,
  input wire logic out_a,
  input wire logic out_b
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  property p_rdy; psel && penable && !pready |=> pready; endproperty
  a_rdy: assert property (p_rdy) else $error("no ready");
  property p_one; pready |=> !pready; endproperty
  a_one: assert property (p_one) else $error("ready held");
  property p_hold; pready |-> psel && penable; endproperty
  a_hold: assert property (p_hold) else $error("stray ready");
  property p_top; pready |-> prdata[31:8] == 24'h0; endproperty
  a_top: assert property (p_top) else $error("upper bits set");
  property p_err; pslverr |-> pready && prdata == 32'h0; endproperty
  a_err: assert property (p_err) else $error("bad error");
  property p_comp; !(out_a && out_b); endproperty
  a_comp: assert property (p_comp) else $error("overlap");
  property p_rise; $rose(wave_in) |-> ##[1:300] (out_a || !wave_in);
  endproperty
  a_rise: assert property (p_rise) else $error("no rise");
  property p_fall; $fell(wave_in) |-> ##[1:300] (out_b || wave_in);
  endproperty
  a_fall: assert property (p_fall) else $error("no fall");
endmodule
////////////////////////////////////////////////////////////////////////////
bind complementary_dead_band_delay dead_band_checker i_dead_band_checker (
  .ref_clk, .sys_rst, .psel, .penable, .prdata, .pready, .pslverr,
  .wave_in, .out_a, .out_b);

// File: test_complementary_dead_band_delay.sv
`include "dead_band_cfg.svh"
module test_complementary_dead_band_delay;
  timeunit 1ns;
  timeprecision 1ns;
  logic ref_clk = 0, sys_rst = 1, psel = 0, penable = 0, pwrite = 0;
  logic wave_in = 0, out_a, out_b, pready, pslverr, alt_clk;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, r;
  logic [32:0] exp_q [$];
  logic [11:0] ofs [5] = '{`OFS_CTRL0, `OFS_CTRL1, `OFS_SHDN,
    `OFS_DB_FALL, `OFS_DB_RISE};
  logic [7:0] msk [5] = '{`CTRL0_IMPL_MASK, `CTRL1_IMPL_MASK,
    `SHDN_IMPL_MASK, 8'h3f, 8'h3f};
  int failures = 0, tests_run = 0, cyc = 0, lo;
  always #25 ref_clk = ~ref_clk;
  alt_tick_src i_alt_tick_src (.alt_clk(alt_clk));
  complementary_dead_band_delay i_complementary_dead_band_delay (
    .ref_clk, .sys_rst, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .wave_in, .alt_clk, .out_a, .out_b);
  task end_of_test;
    $display("failures %0d tests_run %0d", failures, tests_run);
    if (failures == 0 && tests_run > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task chk(input logic [32:0] g, input logic [32:0] e);
    tests_run++;
    if (g !== e) begin
      failures++;
      $display("BAD %0t %h %h", $time, g, e);
    end
  endtask
  // Reads are judged here, against notes left by the bus task
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 8000) begin
      failures++;
      end_of_test;
    end
    if (pready === 1'b1 && pwrite === 1'b0)
      chk({pslverr, prdata}, exp_q.pop_front());
  end
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d,
      input logic [32:0] e);
    if (!w) exp_q.push_back(e);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1;
    @(posedge ref_clk);
    while (pready !== 1'b1) @(posedge ref_clk);
    psel <= 0;
    penable <= 0;
    @(posedge ref_clk);
  endtask
  task gap(input logic v, input int n, input logic s, input logic ck);
    wave_in <= v;
    lo = 0;
    repeat (300) if ((v ? out_a : out_b) !== 1'b1) begin
      @(posedge ref_clk);
      lo += (out_a === 1'b0 && out_b === 1'b0);
    end
    if (ck) chk(s ? lo >= n * 7 / 2 && lo <= n * 4 + 7 :
      lo >= n && lo <= n + (n != 0), 1);
  endtask
  // Both counts get n; the first call only brings the outputs to a known state
  task db(input int n, input logic s, input logic ck);
    apb(1, `OFS_DB_RISE, n, 0);
    apb(1, `OFS_DB_FALL, n, 0);
    apb(1, `OFS_CTRL0, s, 0);
    gap(1, n, s, ck);
    gap(0, n, s, ck);
  endtask
  initial begin
    r = $urandom(43);
    repeat (16) @(posedge ref_clk);
    sys_rst <= 0;
    @(posedge ref_clk);
    for (int i = 0; i < 5; i++) begin
      r = $urandom;
      apb(1, ofs[i], r, 0);
      apb(0, ofs[i], 0, {25'h0, r[7:0] & msk[i]});
    end
    apb(0, 12'h014, 0, {1'b1, 32'h0});
    db(0, 0, 0);
    db(0, 0, 1);
    db(1, 0, 1);
    db(63, 0, 1);
    db($urandom_range(62, 2), 0, 1);
    db(2, 1, 1);
    sys_rst <= 1;
    repeat (3) @(posedge ref_clk);
    sys_rst <= 0;
    @(posedge ref_clk);
    apb(0, `OFS_DB_RISE, 0, 33'h2);
    apb(0, `OFS_DB_FALL, 0, 33'h2);
    repeat (2) @(posedge ref_clk);
    end_of_test;
  end
endmodule
